// ---- hw/pdhsp_host_setup_port.sv ----
// Host setup port: pointer, mask, mode, command registers and colour palette.
// Assumes an Avalon-MM master on clk and asynchronous sync pins from the video side.
// Behaviour
// - Mode writes of pipeline bit 1,0,1 pulse a pipeline reset to input A.
// - Mode writes of load timing bit 0,1,0 pulse load clock resynchronisation.
// - Pointer cycle with both selects low loads the 8-bit indirect pointer.
// - Control cycle at mask pointer stores the mask; all ones passes every bit.
// - Both selects high reach the mode register directly, pointer untouched.
// - Palette cycles load red, green, blue, then the pointer advances.
// - With per-frame calibration set, calibration starts at every vertical sync.
// - Command two selects 24-bit colour, zero pedestal, sync suppressed and ignored.
// - Command three selects mux ratio and programmable clock divide ratio.
// - Command two sits at pointer 06, command three at 07, via control cycles.
// - A read of a selected register returns its current value, the pointer as advanced by palette cycles.
//
// The Avalon-MM interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/1ps
module pdhsp_host_setup_port (
  input  wire logic                         clk,
  input  wire logic                         rstn,
  input  wire logic [4:0]                   address,
  input  wire logic                         read,
  input  wire logic                         write,
  input  wire logic [3:0]                   byteenable,
  input  wire logic [31:0]                  writedata,
  output logic      [31:0]                  readdata,
  output logic                              waitrequest,
  input  wire logic                         vsync_pin,
  input  wire logic                         sync_pin,
  output pdhsp_pkg::pdhsp_video_ctrl_t      video_ctrl,
  output logic                              pipeline_reset,
  output logic                              load_sync,
  output logic                              cal_start,
  output logic                              sync_out,
  output logic                              programmable_clock_output
);
  logic        wait_q;
  logic [31:0] rdata_q;
  logic [7:0]  ptr_q;
  logic [7:0]  mask_q;
  logic [7:0]  mode_q;
  logic [7:0]  cmd1_q;
  logic [7:0]  cmd2_q;
  logic [7:0]  cmd3_q;
  logic [1:0]  pr_hist_q;
  logic [1:0]  ls_hist_q;
  logic        pipe_rst_q;
  logic        load_sync_q;
  logic [2:0]  vs_sync_q;
  logic [2:0]  sy_sync_q;
  logic        vs_state_q;
  logic        cal_q;
  logic        sync_out_q;
  logic [2:0]  div_cnt_q;
  logic        prg_clk_q;
  logic [9:0]  pal_q [0:2][0:255];
  pdhsp_pkg::pdhsp_comp_t comp_q;
  logic        req;
  logic        acc;
  logic        wr_acc;
  logic        rd_acc;
  logic        mapped;
  logic        vs_agree;
  logic [2:0]  div_half;
  logic [7:0]  chk_prev_q;
  logic [1:0]  chk_nwr_q;

  // Component index for the palette array
  function automatic logic [1:0] comp_idx(input pdhsp_pkg::pdhsp_comp_t c);
    unique case (c)
      pdhsp_pkg::PDHSP_RED:   comp_idx = 2'h0;
      pdhsp_pkg::PDHSP_GREEN: comp_idx = 2'h1;
      pdhsp_pkg::PDHSP_BLUE:  comp_idx = 2'h2;
      default:                comp_idx = 2'h0;
    endcase
  endfunction

  // Bus decode; one wait cycle per access keeps read data registered
  assign req    = read | write;
  assign acc    = req & ~wait_q;
  assign wr_acc = write & ~wait_q & byteenable[0] & mapped;
  assign rd_acc = read & ~wait_q & mapped;
  assign mapped = (address[4] == 1'b0) && (address[1:0] == 2'h0);

  // Wait state: low for exactly one cycle after a request is seen
  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
      wait_q <= 1'b1;
    else
      wait_q <= ~(req & wait_q);

  // Read data prepared in the cycle before waitrequest drops
  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
      rdata_q <= 32'h0000_0000;
    else if (read && wait_q)
    begin
      rdata_q <= 32'h0000_0000;
      if (mapped)
        unique case (address)
          pdhsp_pkg::OFS_POINTER: rdata_q[7:0] <= ptr_q;
          pdhsp_pkg::OFS_PALETTE: rdata_q[9:0] <= pal_q[comp_idx(comp_q)][ptr_q];
          pdhsp_pkg::OFS_MODE:    rdata_q[7:0] <= mode_q;
          default:
            unique case (ptr_q)
              pdhsp_pkg::PTR_MASK: rdata_q[7:0] <= mask_q;
              pdhsp_pkg::PTR_CMD1: rdata_q[7:0] <= cmd1_q;
              pdhsp_pkg::PTR_CMD2: rdata_q[7:0] <= cmd2_q;
              pdhsp_pkg::PTR_CMD3: rdata_q[7:0] <= cmd3_q;
              default:             rdata_q[7:0] <= 8'h00;
            endcase
        endcase
    end

  // Pointer and palette component; palette cycles advance the location
  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
    begin
      ptr_q  <= pdhsp_pkg::RST_POINTER;
      comp_q <= pdhsp_pkg::PDHSP_RED;
    end
    else if (wr_acc && address == pdhsp_pkg::OFS_POINTER)
    begin
      ptr_q  <= writedata[7:0];
      comp_q <= pdhsp_pkg::PDHSP_RED;
    end
    else if ((wr_acc || rd_acc) && address == pdhsp_pkg::OFS_PALETTE)
      unique case (comp_q)
        pdhsp_pkg::PDHSP_RED:   comp_q <= pdhsp_pkg::PDHSP_GREEN;
        pdhsp_pkg::PDHSP_GREEN: comp_q <= pdhsp_pkg::PDHSP_BLUE;
        pdhsp_pkg::PDHSP_BLUE:
        begin
          comp_q <= pdhsp_pkg::PDHSP_RED;
          ptr_q  <= ptr_q + 8'h01;
        end
        default: comp_q <= pdhsp_pkg::PDHSP_RED;
      endcase

  // Palette storage; no reset, software initialises it
  always_ff @(posedge clk)
    if (wr_acc && address == pdhsp_pkg::OFS_PALETTE)
      pal_q[comp_idx(comp_q)][ptr_q] <= writedata[9:0];

  // Indirect control registers reached through the pointer
  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
    begin
      mask_q <= pdhsp_pkg::RST_MASK;
      cmd1_q <= pdhsp_pkg::RST_CMD;
      cmd2_q <= pdhsp_pkg::RST_CMD;
      cmd3_q <= pdhsp_pkg::RST_CMD;
    end
    else if (wr_acc && address == pdhsp_pkg::OFS_CONTROL)
      unique case (ptr_q)
        pdhsp_pkg::PTR_MASK: mask_q <= writedata[7:0];
        pdhsp_pkg::PTR_CMD1: cmd1_q <= writedata[7:0];
        pdhsp_pkg::PTR_CMD2: cmd2_q <= writedata[7:0];
        pdhsp_pkg::PTR_CMD3: cmd3_q <= writedata[7:0];
        default:             cmd1_q <= cmd1_q;
      endcase

  // Mode register, direct access without the pointer
  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
      mode_q <= pdhsp_pkg::RST_MODE;
    else if (wr_acc && address == pdhsp_pkg::OFS_MODE)
      mode_q <= writedata[7:0];

  // Bit histories of mode writes; resets start neutral so one write cannot fire
  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
    begin
      pr_hist_q   <= 2'h0;
      ls_hist_q   <= 2'h3;
      pipe_rst_q  <= 1'b0;
      load_sync_q <= 1'b0;
    end
    else
    begin
      pipe_rst_q  <= 1'b0;
      load_sync_q <= 1'b0;
      if (wr_acc && address == pdhsp_pkg::OFS_MODE)
      begin
        pr_hist_q <= {pr_hist_q[0], writedata[pdhsp_pkg::MODE_PIPE_RST]};
        ls_hist_q <= {ls_hist_q[0], writedata[pdhsp_pkg::MODE_LOAD_SYNC]};
        pipe_rst_q  <= (pr_hist_q == 2'h2) && writedata[pdhsp_pkg::MODE_PIPE_RST];
        load_sync_q <= (ls_hist_q == 2'h1) && !writedata[pdhsp_pkg::MODE_LOAD_SYNC];
      end
    end

  // Pin synchronisers; a change counts once stages two and three agree
  assign vs_agree = (vs_sync_q[1] == vs_sync_q[2]);
  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
    begin
      vs_sync_q  <= 3'h0;
      sy_sync_q  <= 3'h0;
      vs_state_q <= 1'b0;
      cal_q      <= 1'b0;
      sync_out_q <= 1'b0;
    end
    else
    begin
      vs_sync_q  <= {vs_sync_q[1:0], vsync_pin};
      sy_sync_q  <= {sy_sync_q[1:0], sync_pin};
      if (vs_agree)
        vs_state_q <= vs_sync_q[2];
      cal_q <= vs_agree && vs_sync_q[2] && !vs_state_q && cmd1_q[pdhsp_pkg::CMD1_CAL_FRAME];
      // Sync input ignored when suppressed
      if (sy_sync_q[1] == sy_sync_q[2])
        sync_out_q <= sy_sync_q[2] & ~cmd2_q[pdhsp_pkg::CMD2_SYNC_OFF];
      else if (cmd2_q[pdhsp_pkg::CMD2_SYNC_OFF])
        sync_out_q <= 1'b0;
    end

  // Programmable clock output; ratio may change mid-period, counter runs on and wraps once it reaches or passes the new half period minus one
  assign div_half = cmd3_q[pdhsp_pkg::CMD3_DIV_FAST] ? pdhsp_pkg::DIV_HALF_FAST
                                                     : pdhsp_pkg::DIV_HALF_SLOW;
  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
    begin
      div_cnt_q <= 3'h0;
      prg_clk_q <= 1'b0;
    end
    else if (div_cnt_q >= div_half - 3'h1)
    begin
      div_cnt_q <= 3'h0;
      prg_clk_q <= ~prg_clk_q;
    end
    else
      div_cnt_q <= div_cnt_q + 3'h1;

  // Outputs, all taken from register bits
  assign readdata                  = rdata_q;
  assign waitrequest               = wait_q;
  assign pipeline_reset            = pipe_rst_q;
  assign load_sync                 = load_sync_q;
  assign cal_start                 = cal_q;
  assign sync_out                  = sync_out_q;
  assign programmable_clock_output = prg_clk_q;
  assign video_ctrl.direct_colour_24 = cmd2_q[pdhsp_pkg::CMD2_DIRECT24];
  assign video_ctrl.pedestal_zero    = cmd2_q[pdhsp_pkg::CMD2_PED_ZERO];
  assign video_ctrl.sync_suppress    = cmd2_q[pdhsp_pkg::CMD2_SYNC_OFF];
  assign video_ctrl.width_10bit      = mode_q[pdhsp_pkg::MODE_WIDTH10];
  assign video_ctrl.mux_ratio        = {cmd3_q[pdhsp_pkg::CMD3_MUX_HI],
                                        cmd3_q[pdhsp_pkg::CMD3_MUX_LO]};
  assign video_ctrl.clk_div_fast     = cmd3_q[pdhsp_pkg::CMD3_DIV_FAST];
  assign video_ctrl.pixel_mask       = mask_q;

  // Checks
  sequence s_mode_wr(int b, logic v);
    wr_acc && address == pdhsp_pkg::OFS_MODE && writedata[b] == v;
  endsequence
  sequence s_mode_before(int b, logic first, logic second);
    chk_nwr_q[1] && chk_prev_q[b] == first && mode_q[b] == second;
  endsequence

  // Check helper: mode value written before the last one; gaps of any length allowed
  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
    begin
      chk_prev_q <= 8'h00;
      chk_nwr_q  <= 2'h0;
    end
    else if (wr_acc && address == pdhsp_pkg::OFS_MODE)
    begin
      chk_prev_q <= mode_q;
      chk_nwr_q  <= {chk_nwr_q[0], 1'b1};
    end

  chk_pipe_reset_seq: assert property (@(posedge clk) disable iff (!rstn)
    s_mode_before(pdhsp_pkg::MODE_PIPE_RST, 1'b1, 1'b0) ##0
    s_mode_wr(pdhsp_pkg::MODE_PIPE_RST, 1'b1) |=> pipeline_reset ##1 !pipeline_reset)
    else $error("pipeline reset not pulsed after 1,0,1");
  chk_load_sync_seq: assert property (@(posedge clk) disable iff (!rstn)
    s_mode_before(pdhsp_pkg::MODE_LOAD_SYNC, 1'b0, 1'b1) ##0
    s_mode_wr(pdhsp_pkg::MODE_LOAD_SYNC, 1'b0) |=> load_sync)
    else $error("load sync not pulsed after 0,1,0");
  chk_ptr_load: assert property (@(posedge clk) disable iff (!rstn)
    wr_acc && address == pdhsp_pkg::OFS_POINTER |=> ptr_q == $past(writedata[7:0]))
    else $error("pointer not loaded");
  chk_mask_store: assert property (@(posedge clk) disable iff (!rstn)
    wr_acc && address == pdhsp_pkg::OFS_CONTROL && ptr_q == pdhsp_pkg::PTR_MASK
    |=> video_ctrl.pixel_mask == $past(writedata[7:0]))
    else $error("pixel mask not stored");
  chk_mode_direct: assert property (@(posedge clk) disable iff (!rstn)
    wr_acc && address == pdhsp_pkg::OFS_MODE |=> mode_q == $past(writedata[7:0]) && $stable(ptr_q))
    else $error("mode write wrong or pointer moved");
  chk_pal_advance: assert property (@(posedge clk) disable iff (!rstn)
    wr_acc && address == pdhsp_pkg::OFS_PALETTE && comp_q == pdhsp_pkg::PDHSP_BLUE
    |=> ptr_q == $past(ptr_q) + 8'h01 && comp_q == pdhsp_pkg::PDHSP_RED)
    else $error("palette did not advance after blue");
  chk_cal_vsync: assert property (@(posedge clk) disable iff (!rstn)
    $rose(vs_state_q) && $past(cmd1_q[pdhsp_pkg::CMD1_CAL_FRAME]) |-> cal_start)
    else $error("no calibration at vertical sync");
  chk_sync_ignore: assert property (@(posedge clk) disable iff (!rstn)
    cmd2_q[pdhsp_pkg::CMD2_SYNC_OFF] [*2] |-> !sync_out)
    else $error("sync passed while suppressed");
  chk_clk_period: assert property (@(posedge clk) disable iff (!rstn)
    cmd3_q[pdhsp_pkg::CMD3_DIV_FAST] [*4] ##0 $rose(prg_clk_q)
    |-> !$past(prg_clk_q, 1) && !$past(prg_clk_q, 2) && $past(prg_clk_q, 3))
    else $error("divide by four period wrong");
  chk_cr_readback: assert property (@(posedge clk) disable iff (!rstn)
    read && wait_q && address == pdhsp_pkg::OFS_CONTROL && ptr_q == pdhsp_pkg::PTR_CMD3
    |=> !waitrequest && readdata == {24'h000000, cmd3_q})
    else $error("command three readback wrong");
endmodule

// ---- hw/pdhsp_pkg.sv ----
// Shared constants and types of the palette converter host setup port.
// Assumes a 40 MHz system clock and an Avalon-MM master with 32-bit data.
package pdhsp_pkg;
  // Byte offsets of the four select-line cycles (bit 3 = upper, bit 2 = lower)
  localparam logic [4:0] OFS_POINTER = 5'h00;
  localparam logic [4:0] OFS_PALETTE = 5'h04;
  localparam logic [4:0] OFS_CONTROL = 5'h08;
  localparam logic [4:0] OFS_MODE    = 5'h0c;
  // Pointer values of the indirect control registers
  localparam logic [7:0] PTR_MASK = 8'h04;
  localparam logic [7:0] PTR_CMD1 = 8'h05;
  localparam logic [7:0] PTR_CMD2 = 8'h06;
  localparam logic [7:0] PTR_CMD3 = 8'h07;
  // Reset values
  localparam logic [7:0] RST_POINTER = 8'h00;
  localparam logic [7:0] RST_MASK    = 8'hff;
  localparam logic [7:0] RST_MODE    = 8'h00;
  localparam logic [7:0] RST_CMD     = 8'h00;
  // Field positions
  localparam int MODE_PIPE_RST  = 0;
  localparam int MODE_WIDTH10   = 1;
  localparam int MODE_LOAD_SYNC = 5;
  localparam int CMD1_CAL_FRAME = 6;
  localparam int CMD2_DIRECT24  = 7;
  localparam int CMD2_PED_ZERO  = 6;
  localparam int CMD2_SYNC_OFF  = 5;
  localparam int CMD3_DIV_FAST  = 7;
  localparam int CMD3_MUX_HI    = 6;
  localparam int CMD3_MUX_LO    = 5;
  // Clock output half periods in system clocks (divide by 4 and by 8)
  localparam logic [2:0] DIV_HALF_FAST = 3'h2;
  localparam logic [2:0] DIV_HALF_SLOW = 3'h4;
  // Palette component order
  typedef enum logic [2:0] {
    PDHSP_RED   = 3'b001,
    PDHSP_GREEN = 3'b010,
    PDHSP_BLUE  = 3'b100
  } pdhsp_comp_t;
  // Video path settings taken from the command, mask and mode registers
  typedef struct packed {
    logic       direct_colour_24;
    logic       pedestal_zero;
    logic       sync_suppress;
    logic       width_10bit;
    logic [1:0] mux_ratio;
    logic       clk_div_fast;
    logic [7:0] pixel_mask;
  } pdhsp_video_ctrl_t;
endpackage

// ---- verification/pdhsp_host_model.sv ----
// Host processor model: Avalon-MM master for the setup port.
// Assumes callers enter its task just after a rising edge of clk.
`timescale 1ns/1ps
module pdhsp_host_model (
  input  wire logic        clk,
  input  wire logic        waitrequest,
  input  wire logic [31:0] readdata,
  output logic      [4:0]  address,
  output logic             read,
  output logic             write,
  output logic      [3:0]  byteenable,
  output logic      [31:0] writedata
);
  int hangs = 0;

  // Bus idle from time zero
  initial
  begin
    address = 5'h00;
    read = 1'b0;
    write = 1'b0;
    byteenable = 4'hf;
    writedata = 32'h0;
  end

  // One cycle: hold all until waitrequest is sampled low, then release
  task automatic access(input logic is_rd, input logic [4:0] a, input logic [31:0] d,
                        input logic [3:0] be, output logic [31:0] q);
    address <= a;
    writedata <= d;
    byteenable <= be;
    read <= is_rd;
    write <= !is_rd;
    @(posedge clk);
    // No cycle count assumed; only the bench watchdog ends a stuck wait
    while (waitrequest !== 1'b0)
      @(posedge clk);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge clk); // Gap keeps the next request off this edge
    if (waitrequest !== 1'b1) hangs++; // Answer must stand for one cycle only
  endtask
endmodule

// ---- verification/pdhsp_host_setup_port_tb.sv ----
// Self-checking bench of the host setup port, driven through the host model.
// Assumes a 40 MHz clock and the pointer values of the package.
`timescale 1ns/1ps
module pdhsp_host_setup_port_tb;
  logic                         clk, rstn, vsync_pin, sync_pin, read, write, waitrequest;
  logic                         pipeline_reset, load_sync, cal_start, sync_out, prg_clk;
  logic [4:0]                   address;
  logic [3:0]                   byteenable;
  logic [31:0]                  writedata, readdata, q;
  pdhsp_pkg::pdhsp_video_ctrl_t video_ctrl;
  int                           num_errors = 0, num_checks = 0, n_pipe = 0, n_load = 0, n_cal = 0;
  int                           p;

  pdhsp_host_setup_port DUT (.clk(clk), .rstn(rstn), .address(address), .read(read),
    .write(write), .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .vsync_pin(vsync_pin), .sync_pin(sync_pin),
    .video_ctrl(video_ctrl), .pipeline_reset(pipeline_reset), .load_sync(load_sync),
    .cal_start(cal_start), .sync_out(sync_out), .programmable_clock_output(prg_clk));
  pdhsp_host_model host (.clk(clk), .waitrequest(waitrequest), .readdata(readdata),
    .address(address), .read(read), .write(write), .byteenable(byteenable),
    .writedata(writedata));

  // 25 ns clock
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Count the one-cycle pulses
  always @(posedge clk)
  begin
    if (pipeline_reset === 1'b1) n_pipe++;
    if (load_sync === 1'b1) n_load++;
    if (cal_start === 1'b1) n_cal++;
  end

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] unused;
    host.access(1'b0, a, d, 4'hf, unused);
  endtask

  task automatic rd(input logic [4:0] a, output logic [31:0] r);
    host.access(1'b1, a, 32'h0, 4'hf, r);
  endtask

  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Cycles between the 2nd and 3rd rise of the divided clock
  task automatic measure(output int per);
    int e[$];
    logic prev;
    prev = prg_clk;
    for (int i = 0; i < 40; i++)
    begin
      @(posedge clk);
      if (prg_clk === 1'b1 && prev === 1'b0) e.push_back(i);
      prev = prg_clk;
    end
    per = (e.size() > 2) ? e[2] - e[1] : 0;
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Watchdog well beyond the roughly 265 cycles the tests need
  initial
  begin
    repeat (5000) @(posedge clk);
    num_errors++;
    report_and_stop();
  end

  initial
  begin
    rstn = 1'b0;
    vsync_pin = 1'b0;
    sync_pin = 1'b1;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    cmp("mask at reset", 32'hff, 32'(video_ctrl.pixel_mask));
    rd(pdhsp_pkg::OFS_MODE, q);
    cmp("mode at reset", 32'h0, q);
    $display("test reset done");
    wr(pdhsp_pkg::OFS_POINTER, 32'(pdhsp_pkg::PTR_MASK));
    wr(pdhsp_pkg::OFS_CONTROL, 32'h5a);
    cmp("mask", 32'h5a, 32'(video_ctrl.pixel_mask));
    wr(pdhsp_pkg::OFS_MODE, 32'h02);
    cmp("width", 32'h1, 32'(video_ctrl.width_10bit));
    rd(pdhsp_pkg::OFS_CONTROL, q);
    cmp("mask after mode", 32'h5a, q);
    wr(pdhsp_pkg::OFS_CONTROL, 32'hff);
    cmp("mask all ones", 32'hff, 32'(video_ctrl.pixel_mask));
    host.access(1'b0, pdhsp_pkg::OFS_MODE, 32'h00, 4'he, q);
    rd(pdhsp_pkg::OFS_MODE, q);
    cmp("mode kept without low lane", 32'h02, q);
    rd(5'h10, q);
    cmp("unmapped read", 32'h0, q);
    $display("test pointer mask mode done");
    cmp("sync passed", 32'h1, 32'(sync_out));
    wr(pdhsp_pkg::OFS_POINTER, 32'(pdhsp_pkg::PTR_CMD2));
    wr(pdhsp_pkg::OFS_CONTROL, 32'he0);
    rd(pdhsp_pkg::OFS_CONTROL, q);
    cmp("cmd2", 32'he0, q);
    cmp("cmd2 fields", 32'h7, 32'({video_ctrl.direct_colour_24, video_ctrl.pedestal_zero,
        video_ctrl.sync_suppress}));
    repeat (6) @(posedge clk);
    cmp("sync out", 32'h0, 32'(sync_out));
    wr(pdhsp_pkg::OFS_POINTER, 32'(pdhsp_pkg::PTR_CMD3));
    wr(pdhsp_pkg::OFS_CONTROL, 32'h40);
    rd(pdhsp_pkg::OFS_CONTROL, q);
    cmp("cmd3", 32'h40, q);
    cmp("mux ratio", 32'h2, 32'(video_ctrl.mux_ratio));
    measure(p);
    cmp("slow clock period", 32'd8, 32'(p));
    wr(pdhsp_pkg::OFS_CONTROL, 32'hc0);
    cmp("divide fast", 32'h1, 32'(video_ctrl.clk_div_fast));
    measure(p);
    cmp("fast clock period", 32'd4, 32'(p));
    wr(pdhsp_pkg::OFS_POINTER, 32'(pdhsp_pkg::PTR_CMD2));
    rd(pdhsp_pkg::OFS_CONTROL, q);
    cmp("cmd2 later", 32'he0, q);
    $display("test command registers done");
    for (int k = 0; k < 2; k++)
    begin
      wr(pdhsp_pkg::OFS_POINTER, 32'(pdhsp_pkg::PTR_CMD1));
      wr(pdhsp_pkg::OFS_CONTROL, (k == 0) ? 32'h40 : 32'h00);
      vsync_pin <= 1'b1;
      repeat (10) @(posedge clk);
      vsync_pin <= 1'b0;
      repeat (10) @(posedge clk);
      cmp("calibration starts", 32'd1, 32'(n_cal));
    end
    $display("test calibration done");
    wr(pdhsp_pkg::OFS_MODE, 32'h01);
    wr(pdhsp_pkg::OFS_MODE, 32'h00);
    cmp("no early pipeline reset", 32'd0, 32'(n_pipe));
    wr(pdhsp_pkg::OFS_MODE, 32'h01);
    repeat (3) @(posedge clk);
    cmp("pipeline reset", 32'd1, 32'(n_pipe));
    cmp("no early load sync", 32'd0, 32'(n_load));
    wr(pdhsp_pkg::OFS_MODE, 32'h20);
    wr(pdhsp_pkg::OFS_MODE, 32'h00);
    repeat (3) @(posedge clk);
    cmp("load sync", 32'd1, 32'(n_load));
    cmp("pipeline reset once", 32'd1, 32'(n_pipe));
    $display("test mode sequences done");
    wr(pdhsp_pkg::OFS_POINTER, 32'h00);
    for (int i = 0; i < 6; i++) wr(pdhsp_pkg::OFS_PALETTE, 32'h3a0 + 32'(i));
    wr(pdhsp_pkg::OFS_POINTER, 32'h00);
    for (int i = 0; i < 6; i++)
    begin
      rd(pdhsp_pkg::OFS_PALETTE, q);
      cmp("palette", 32'h3a0 + 32'(i), q);
    end
    wr(pdhsp_pkg::OFS_POINTER, 32'h01);
    rd(pdhsp_pkg::OFS_PALETTE, q);
    cmp("palette red of 01", 32'h3a3, q);
    cmp("bus hangs", 32'h0, 32'(host.hangs));
    $display("test palette done");
    report_and_stop();
  end
endmodule
